// File: core/risc_decode_pkg.sv
// Shared constants for the 14-bit instruction decode and execute core.
package risc_decode_pkg;

  // ----------------------------------------------------------------
  // Instruction format selectors (bits 13:12).
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_BYTE = 2'h0;  // Byte-oriented file operations.
  localparam logic [1:0] FMT_BIT  = 2'h1;  // Bit-oriented file operations.
  localparam logic [1:0] FMT_JUMP = 2'h2;  // Call and jump.
  localparam logic [1:0] FMT_LIT  = 2'h3;  // Literal operations.

  // ----------------------------------------------------------------
  // Byte-oriented operation nibbles (bits 11:8).
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_MISC      = 4'h0;  // Fixed control words and acc store.
  localparam logic [3:0] OP_OR_FILE   = 4'h4;  // or_acc_file.
  localparam logic [3:0] OP_XOR_FILE  = 4'h6;  // xor_acc_file.
  localparam logic [3:0] OP_DEC_SKIP  = 4'hb;  // dec_skip_nil.
  localparam logic [3:0] OP_ROT_DOWN  = 4'hc;  // rotate_down_file.
  localparam logic [3:0] OP_ROT_UP    = 4'hd;  // rotate_up_file.
  localparam logic [3:0] OP_NIB_SWAP  = 4'he;  // nibble_exchange.
  localparam logic [3:0] OP_INC_SKIP  = 4'hf;  // inc_skip_nil.

  // ----------------------------------------------------------------
  // Bit-oriented sub-codes (bits 11:10) and literal sub-codes (bits 11:8).
  // ----------------------------------------------------------------
  localparam logic [1:0] BIT_SKIP_LOW  = 2'h2;  // bit_test_skip_low.
  localparam logic [1:0] BIT_SKIP_HIGH = 2'h3;  // bit_test_skip_high.
  localparam logic [3:0] LIT_OR        = 4'h8;  // or_literal_acc.
  localparam logic [2:0] LIT_MINUS     = 3'h6;  // literal_minus_acc, bits 11:9.
  localparam logic [1:0] LIT_RETURN    = 2'h1;  // return_with_constant, bits 11:10.
  localparam logic [1:0] LIT_LOAD      = 2'h0;  // Literal load into the accumulator, bits 11:10.

  // ----------------------------------------------------------------
  // Fixed control words.
  // ----------------------------------------------------------------
  localparam logic [13:0] WORD_SLEEP      = 14'h0063;  // Standby entry.
  localparam logic [13:0] WORD_IRQ_RETURN = 14'h0009;  // irq_return.

  // ----------------------------------------------------------------
  // Register file addresses and field positions.
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_TIMER_ZERO = 7'h01;  // timer_zero_count.
  localparam logic [6:0] ADDR_PORT_A     = 7'h05;  // First port register.
  localparam logic [6:0] ADDR_PORT_C     = 7'h07;  // Last port register.
  localparam logic [6:0] ADDR_IRQ_CTRL   = 7'h0b;  // irq_control_reg.
  localparam int         GLOBAL_IRQ_BIT  = 7;      // global_irq_allow position.
  localparam logic [7:0] IRQ_CTRL_RESET  = 8'h00;  // irq_control_reg after reset.
  localparam int         STACK_DEPTH     = 8;      // Hardware return stack depth.

  // ----------------------------------------------------------------
  // Wishbone register map (word addresses in byte units).
  // ----------------------------------------------------------------
  localparam logic [7:0] WB_ADDR_CTRL   = 8'h00;  // Run enable and prescaler assignment.
  localparam logic [7:0] WB_ADDR_ACC    = 8'h04;  // Accumulator, read only.
  localparam logic [7:0] WB_ADDR_STATUS = 8'h08;  // Flags, read only.
  localparam logic [7:0] WB_ADDR_PC     = 8'h0c;  // Program counter, read only.
  localparam logic [7:0] WB_ADDR_IRQ    = 8'h10;  // irq_control_reg, read and write.
  localparam int         CTRL_RUN_BIT   = 0;      // Core runs while set.
  localparam int         CTRL_PSA_BIT   = 1;      // Prescaler assigned to timer while set.

endpackage : risc_decode_pkg

// File: core/risc_instruction_decoder.sv
// Decode and execute core for a 14-bit instruction word with a Wishbone view.
//
// Operation
// - Nibble 0110: xor acc with file, zero flag
// - Nibble 0100: or acc with file, zero flag
// - Nibble 1011: decrement, skip when result zero
// - Nibble 1111: increment, skip when result zero
// - Nibble 1101: rotate left through carry
// - Nibble 1100: rotate right through carry
// - Bit pattern 10bb: skip when bit clear
// - Bit pattern 11bb: skip when bit set
// - Literal 110x: literal minus acc, C DC Z
// - Literal 1000: or literal into acc, Z
// - Standby word: one cycle, sets timeout flag, clears sleep flag
// - Port read-modify-write uses pin levels
// - Timer write clears prescaler when assigned
// - PC change or true test: two cycles
// - Interrupt return pops stack, sets global enable
// - Literal 01xx: load acc, return from stack
// - Nibble 1110: swap nibbles to destination
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module risc_instruction_decoder #(
  parameter int FILE_DEPTH = 128  // Number of data file locations.
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Program memory.
  output logic [10:0]      pc_o,
  input  wire logic [13:0] instr_i,
  // Port pins, eight bits for each of three ports.
  input  wire logic [23:0] port_pins_i,
  output logic [23:0]      port_latch_o,
  // Core status.
  output logic             sleeping_o,
  output logic             prescaler_clear_o,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [23:0] pin_s1_q;   // First stage, read only by the second.
  logic [23:0] pin_s2_q;   // Second stage.
  logic [23:0] pin_s3_q;   // Third stage.
  logic [23:0] pin_q;      // Accepted pin level.

  // Three flops; a new level is accepted once stages two and three agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 24'h000000;
      pin_s2_q <= 24'h000000;
      pin_s3_q <= 24'h000000;
      pin_q    <= 24'h000000;
    end else begin
      pin_s1_q <= port_pins_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 24; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Architectural state.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,  // Execute a fetched word.
    ST_FLUSH = 2'b01,  // Second cycle, executed as a no-op.
    ST_SLEEP = 2'b11   // Standby, leaves only by reset.
  } exec_state_e;

  exec_state_e  state_q;                       // Sequencer state.
  logic [7:0]   acc_q;                         // Accumulator.
  logic         carry_q;                       // borrow_out_flag.
  logic         half_q;                        // half_byte_carry.
  logic         zero_q;                        // all_nil_result_flag.
  logic         wd_expiry_q;                   // watchdog_expiry_flag, active low sense.
  logic         sleep_flag_q;                  // sleep_entered_flag, active low sense.
  logic [7:0]   irq_ctrl_q;                    // irq_control_reg.
  logic [7:0]   file_q [FILE_DEPTH];           // Data file.
  logic [10:0]  stack_q [risc_decode_pkg::STACK_DEPTH]; // Return stack.
  logic [2:0]   sp_q;                          // Next free stack slot.
  logic         run_q;                         // Software run enable.
  logic         psa_q;                         // Prescaler assigned to timer.

  // ----------------------------------------------------------------
  // Decode fields.
  // ----------------------------------------------------------------
  logic [1:0] fmt;
  logic [3:0] opn;
  logic       dst;
  logic [6:0] fadr;
  logic [2:0] bsel;
  logic [7:0] lit;
  assign fmt  = instr_i[13:12];
  assign opn  = instr_i[11:8];
  assign dst  = instr_i[7];
  assign fadr = instr_i[6:0];
  assign bsel = instr_i[9:7];
  assign lit  = instr_i[7:0];

  // Port registers read back the synchronised pins, not the latches.
  logic       is_port;
  logic [7:0] fval;
  assign is_port = (fadr >= risc_decode_pkg::ADDR_PORT_A) && (fadr <= risc_decode_pkg::ADDR_PORT_C);
  always_comb begin
    fval = file_q[fadr];
    if (is_port) begin
      fval = pin_q[8 * (fadr - risc_decode_pkg::ADDR_PORT_A) +: 8];
    end else if (fadr == risc_decode_pkg::ADDR_IRQ_CTRL) begin
      fval = irq_ctrl_q;
    end
  end

  // ----------------------------------------------------------------
  // Execute decode: result, destination and flag effects.
  // ----------------------------------------------------------------
  logic [7:0] res;        // Result value.
  logic       wr_file;    // Write result to file.
  logic       wr_acc;     // Write result to accumulator.
  logic       upd_z;      // Update zero flag.
  logic       upd_c;      // Update carry flag.
  logic       new_c;      // New carry.
  logic       upd_dc;     // Update half carry.
  logic       new_dc;     // New half carry.
  logic       two_cyc;    // Second cycle needed.
  logic       do_sleep;   // Enter standby.
  logic       do_pop;     // Pop stack into PC.
  logic       do_push;    // Push return address.
  logic       do_jump;    // Load jump target.
  logic       set_gie;    // Set global_irq_allow.
  logic [8:0] diff;       // Subtraction with borrow.
  logic [4:0] hdiff;      // Low nibble subtraction.

  always_comb begin
    res      = 8'h00;
    wr_file  = 1'b0;
    wr_acc   = 1'b0;
    upd_z    = 1'b0;
    upd_c    = 1'b0;
    new_c    = 1'b0;
    upd_dc   = 1'b0;
    new_dc   = 1'b0;
    two_cyc  = 1'b0;
    do_sleep = 1'b0;
    do_pop   = 1'b0;
    do_push  = 1'b0;
    do_jump  = 1'b0;
    set_gie  = 1'b0;
    diff     = {1'b0, lit} - {1'b0, acc_q};
    hdiff    = {1'b0, lit[3:0]} - {1'b0, acc_q[3:0]};
    case (fmt)
      risc_decode_pkg::FMT_BYTE: begin
        wr_file = dst;
        wr_acc  = ~dst;
        case (opn)
          risc_decode_pkg::OP_XOR_FILE: begin
            res   = acc_q ^ fval;
            upd_z = 1'b1;
          end
          risc_decode_pkg::OP_OR_FILE: begin
            res   = acc_q | fval;
            upd_z = 1'b1;
          end
          risc_decode_pkg::OP_DEC_SKIP: begin
            res     = fval - 8'h01;
            two_cyc = (res == 8'h00);
          end
          risc_decode_pkg::OP_INC_SKIP: begin
            res     = fval + 8'h01;
            two_cyc = (res == 8'h00);
          end
          risc_decode_pkg::OP_ROT_UP: begin
            res   = {fval[6:0], carry_q};
            upd_c = 1'b1;
            new_c = fval[7];
          end
          risc_decode_pkg::OP_ROT_DOWN: begin
            res   = {carry_q, fval[7:1]};
            upd_c = 1'b1;
            new_c = fval[0];
          end
          risc_decode_pkg::OP_NIB_SWAP: begin
            res = {fval[3:0], fval[7:4]};
          end
          default: begin
            // Fixed control words and the acc store share the zero nibble; all else is a no-op.
            wr_file = 1'b0;
            wr_acc  = 1'b0;
            if (instr_i == risc_decode_pkg::WORD_SLEEP) begin
              do_sleep = 1'b1;
            end else if (instr_i == risc_decode_pkg::WORD_IRQ_RETURN) begin
              do_pop  = 1'b1;
              set_gie = 1'b1;
              two_cyc = 1'b1;
            end else if ((opn == risc_decode_pkg::OP_MISC) && dst) begin
              res     = acc_q;  // Accumulator store to the file, no flags touched.
              wr_file = 1'b1;
            end
          end
        endcase
      end
      risc_decode_pkg::FMT_BIT: begin
        if (opn[3:2] == risc_decode_pkg::BIT_SKIP_LOW) begin
          two_cyc = ~fval[bsel];
        end else if (opn[3:2] == risc_decode_pkg::BIT_SKIP_HIGH) begin
          two_cyc = fval[bsel];
        end
      end
      risc_decode_pkg::FMT_JUMP: begin
        do_jump = 1'b1;
        do_push = ~opn[3];
        two_cyc = 1'b1;
      end
      default: begin
        if (opn == risc_decode_pkg::LIT_OR) begin
          res    = acc_q | lit;
          wr_acc = 1'b1;
          upd_z  = 1'b1;
        end else if (opn[3:1] == risc_decode_pkg::LIT_MINUS) begin
          res    = diff[7:0];
          wr_acc = 1'b1;
          upd_z  = 1'b1;
          upd_c  = 1'b1;
          new_c  = ~diff[8];   // Carry set means no borrow.
          upd_dc = 1'b1;
          new_dc = ~hdiff[4];
        end else if (opn[3:2] == risc_decode_pkg::LIT_RETURN) begin
          res     = lit;
          wr_acc  = 1'b1;
          do_pop  = 1'b1;
          two_cyc = 1'b1;
        end else if (opn[3:2] == risc_decode_pkg::LIT_LOAD) begin
          res    = lit;  // Literal load into the accumulator, no flags.
          wr_acc = 1'b1;
        end
      end
    endcase
  end

  logic exec;  // An instruction executes this cycle.
  assign exec = (state_q == ST_EXEC) && run_q;

  // Sequencer: a true test or PC change adds one flushed cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_EXEC;
    end else if (exec && do_sleep) begin
      state_q <= ST_SLEEP;
    end else if (exec && two_cyc) begin
      state_q <= ST_FLUSH;
    end else if (state_q == ST_FLUSH) begin
      state_q <= ST_EXEC;
    end
  end

  // Program counter and return stack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= 11'h000;
      sp_q <= 3'h0;
    end else if (exec) begin
      if (do_jump) begin
        pc_o <= instr_i[10:0];
      end else if (do_pop) begin
        pc_o <= stack_q[sp_q - 3'h1];
      end else if (!do_sleep) begin
        // A true skip steps over the next word here, so the flush cycle leaves the pc alone.
        pc_o <= pc_o + 11'h001 + {10'h000, two_cyc};
      end
      if (do_push) begin
        stack_q[sp_q] <= pc_o + 11'h001;
        sp_q          <= sp_q + 3'h1;
      end else if (do_pop) begin
        sp_q <= sp_q - 3'h1;
      end
    end
  end

  // Accumulator and arithmetic flags.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q   <= 8'h00;
      carry_q <= 1'b0;
      half_q  <= 1'b0;
      zero_q  <= 1'b0;
    end else if (exec) begin
      if (wr_acc) begin
        acc_q <= res;
      end
      if (upd_z) begin
        zero_q <= (res == 8'h00);
      end
      if (upd_c) begin
        carry_q <= new_c;
      end
      if (upd_dc) begin
        half_q <= new_dc;
      end
    end
  end

  // Power flags: standby clears the sleep flag and sets the timeout flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_expiry_q  <= 1'b1;
      sleep_flag_q <= 1'b1;
      sleeping_o   <= 1'b0;
    end else if (exec && do_sleep) begin
      wd_expiry_q  <= 1'b1;
      sleep_flag_q <= 1'b0;
      sleeping_o   <= 1'b1;
    end
  end

  // A bus write is taken on the request edge, while ack is still low.
  logic wb_ack_d_w;  // A write is taken this cycle.
  assign wb_ack_d_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  // Data file, port latches, interrupt control and prescaler clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_latch_o      <= 24'h000000;
      irq_ctrl_q        <= risc_decode_pkg::IRQ_CTRL_RESET;
      prescaler_clear_o <= 1'b0;
    end else begin
      prescaler_clear_o <= exec && wr_file && psa_q && (fadr == risc_decode_pkg::ADDR_TIMER_ZERO);
      if (exec && wr_file) begin
        file_q[fadr] <= res;
        if (is_port) begin
          port_latch_o[8 * (fadr - risc_decode_pkg::ADDR_PORT_A) +: 8] <= res;
        end
      end
      // Core writes win over a bus write in the same cycle.
      if (exec && set_gie) begin
        irq_ctrl_q[risc_decode_pkg::GLOBAL_IRQ_BIT] <= 1'b1;
      end else if (exec && wr_file && (fadr == risc_decode_pkg::ADDR_IRQ_CTRL)) begin
        irq_ctrl_q <= res;
      end else if (wb_ack_d_w && (wb_adr_i == risc_decode_pkg::WB_ADDR_IRQ) && wb_sel_i[0]) begin
        irq_ctrl_q <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, ack lasts one cycle.
  // ----------------------------------------------------------------
  // Control register and read data; unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      run_q    <= 1'b0;
      psa_q    <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_ack_d_w && (wb_adr_i == risc_decode_pkg::WB_ADDR_CTRL) && wb_sel_i[0]) begin
        run_q <= wb_dat_i[risc_decode_pkg::CTRL_RUN_BIT];
        psa_q <= wb_dat_i[risc_decode_pkg::CTRL_PSA_BIT];
      end
      case (wb_adr_i)
        risc_decode_pkg::WB_ADDR_CTRL:   wb_dat_o <= {30'h00000000, psa_q, run_q};
        risc_decode_pkg::WB_ADDR_ACC:    wb_dat_o <= {24'h000000, acc_q};
        risc_decode_pkg::WB_ADDR_STATUS: wb_dat_o <= {27'h0000000, wd_expiry_q, sleep_flag_q,
                                                      zero_q, half_q, carry_q};
        risc_decode_pkg::WB_ADDR_PC:     wb_dat_o <= {21'h000000, pc_o};
        risc_decode_pkg::WB_ADDR_IRQ:    wb_dat_o <= {24'h000000, irq_ctrl_q};
        default:                         wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule : risc_instruction_decoder

// File: verification/prog_memory_model.sv
// Combinational program memory holding a seven-word image.
`timescale 1ns/1ps
module prog_memory_model (
  // Fetch side.
  input  wire logic [10:0] pc_i,
  output logic      [13:0] instr_o,
  // Image loaded by the bench.
  input  wire logic [13:0] image_i [7]
);
  // Fetches past the image read the standby word, so a runaway program halts.
  assign instr_o = (pc_i < 11'h007) ? image_i[pc_i[2:0]] : risc_decode_pkg::WORD_SLEEP;
endmodule : prog_memory_model

// File: verification/risc_decoder_properties.sv
// Port-level checks for the instruction decoder core.
`timescale 1ns/1ps
module risc_decoder_checker #(
  parameter int FILE_DEPTH = 128  // Data file size, passed on from the core.
) (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Program side and pins.
  input wire logic [10:0] pc_o,
  input wire logic [13:0] instr_i,
  input wire logic [23:0] port_latch_o,
  input wire logic        sleeping_o,
  input wire logic        prescaler_clear_o,
  // Wishbone.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  // ----------------------------------------------------------------
  // Properties, one clock domain.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // The slave answers a fresh request after exactly one wait state.
  property p_ack_latency;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  // An unmapped read returns zero.
  property p_unmapped_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h14 |=> wb_dat_o == 32'h0;
  endproperty
  property p_reset_values;
    $fell(rst_i) |-> pc_o == 11'h0 && port_latch_o == 24'h0 && !sleeping_o && !wb_ack_o;
  endproperty
  property p_sleep_hold;
    sleeping_o |=> sleeping_o;
  endproperty
  // Standby is entered only by the standby word.
  property p_sleep_cause;
    $rose(sleeping_o) |-> $past(instr_i) == risc_decode_pkg::WORD_SLEEP;
  endproperty
  // Once halted, fetching stops.
  property p_sleep_stops;
    sleeping_o |=> $stable(pc_o);
  endproperty
  // Latches move only after an instruction addressed a port.
  property p_latch_cause;
    $changed(port_latch_o) |-> $past(instr_i[6:0]) inside {[7'h05:7'h07]};
  endproperty
  // The prescaler pulse needs a preceding timer access.
  property p_psc_cause;
    prescaler_clear_o |-> $past(instr_i[6:0], 2) == 7'h01 || $past(instr_i[6:0]) == 7'h01;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("ack not one cycle after request");
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
  a_reset_values: assert property (p_reset_values) else $error("outputs not cleared by reset");
  a_sleep_hold: assert property (p_sleep_hold) else $error("standby left without reset");
  a_sleep_cause: assert property (p_sleep_cause) else $error("standby without its word");
  a_sleep_stops: assert property (p_sleep_stops) else $error("pc moved in standby");
  a_latch_cause: assert property (p_latch_cause) else $error("port latch changed unasked");
  a_psc_cause: assert property (p_psc_cause) else $error("prescaler clear without timer write");
  c_sleep: cover property (sleeping_o);
  c_psc: cover property (prescaler_clear_o);
  c_latch: cover property ($changed(port_latch_o));
endmodule : risc_decoder_checker

bind risc_instruction_decoder risc_decoder_checker #(.FILE_DEPTH(FILE_DEPTH)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .pc_o(pc_o), .instr_i(instr_i), .port_latch_o(port_latch_o),
  .sleeping_o(sleeping_o), .prescaler_clear_o(prescaler_clear_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// File: verification/risc_instruction_decoder_tb.sv
// Self-checking bench for the instruction decoder core.
`timescale 1ns/1ps
module risc_instruction_decoder_tb;
  // ----------------------------------------------------------------
  // Programs, each run until it executes a standby word; expected acc and status.
  // ----------------------------------------------------------------
  localparam logic [13:0] PROG [11][7] = '{
    '{14'h305a, 14'h00a0, 14'h300c, 14'h06a0, 14'h0e20, 14'h0063, 14'h0063},
    '{14'h3000, 14'h00a1, 14'h0421, 14'h0070, 14'h0081, 14'h0063, 14'h0063},
    '{14'h3001, 14'h00a2, 14'h0ba2, 14'h3077, 14'h0063, 14'h0063, 14'h0063},
    '{14'h30ff, 14'h00a3, 14'h0f23, 14'h3077, 14'h0063, 14'h0063, 14'h0063},
    '{14'h3005, 14'h3c03, 14'h00a4, 14'h0d24, 14'h0063, 14'h0063, 14'h0063},
    '{14'h3002, 14'h00a5, 14'h3000, 14'h3c00, 14'h0c25, 14'h3800, 14'h0063},
    '{14'h3004, 14'h00a6, 14'h1826, 14'h3033, 14'h1d26, 14'h3011, 14'h1926},
    '{14'h2004, 14'h0063, 14'h0000, 14'h0000, 14'h343c, 14'h30ee, 14'h0063},
    '{14'h3000, 14'h2803, 14'h3055, 14'h380a, 14'h0063, 14'h0063, 14'h0063},
    '{14'h2003, 14'h3066, 14'h0063, 14'h0009, 14'h0063, 14'h0063, 14'h0063},
    '{14'h30ff, 14'h0085, 14'h3000, 14'h0405, 14'h0081, 14'h0063, 14'h0063}};
  localparam logic [7:0] ACC_EXP [11] = '{8'h65, 8'h00, 8'h01, 8'h00, 8'hfc, 8'h81, 8'h04, 8'h3c, 8'h0a, 8'h66, 8'h00};
  localparam logic [7:0] ST_MSK [11] = '{8'h1c, 8'h1c, 8'h18, 8'h18, 8'h1f, 8'h1f, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18};
  localparam logic [7:0] ST_EXP [11] = '{8'h10, 8'h14, 8'h10, 8'h10, 8'h11, 8'h12, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10};
  // Where the pc rests in standby: skips, jumps and returns decide it.
  localparam logic [10:0] PC_EXP [11] = '{11'h005, 11'h005, 11'h004, 11'h004, 11'h004, 11'h006,
                                           11'h007, 11'h001, 11'h004, 11'h002, 11'h005};
  // ----------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleeping_o, prescaler_clear_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [10:0] pc_o;
  logic [13:0] instr_i;
  logic [13:0] image [7];
  logic [23:0] port_pins_i, port_latch_o;
  logic [31:0] exp_q[$], msk_q[$];  // Notes of expected read data and compare masks.
  int          error_cnt, n_tests, pulses;
  integer      seed = 32'h1953dac7;

  risc_instruction_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .pc_o(pc_o), .instr_i(instr_i),
    .port_pins_i(port_pins_i), .port_latch_o(port_latch_o), .sleeping_o(sleeping_o),
    .prescaler_clear_o(prescaler_clear_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  prog_memory_model u_mem (.pc_i(pc_o), .instr_o(instr_i), .image_i(image));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Counts prescaler clear pulses since the last reset.
  always @(posedge clk_i) begin
    if (rst_i) pulses <= 0;
    else if (prescaler_clear_o === 1'b1) pulses <= pulses + 1;
  end

  // Takes the oldest note whenever read data is acknowledged.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check("wb_dat_o", wb_dat_o & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // One classic cycle; a read notes d masked by m as its expected data.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d, input logic [31:0] m);
    int n;
    if (!we) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, d, 4'hf};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n == 20) begin
      error_cnt++;
      end_of_test();
    end
  endtask : bus

  // Resets, loads a program with random pins, runs it to standby, then inspects.
  task automatic run_case(input int i);
    logic [31:0] r;
    int          n;
    r = $random(seed);
    @(posedge clk_i);
    rst_i <= 1'b1;
    image <= PROG[i];
    port_pins_i <= r[23:0] & 24'hfffffe;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, risc_decode_pkg::WB_ADDR_IRQ, 32'h05, 32'h0);
    bus(1'b1, 8'h14, 32'hffffffff, 32'h0);
    bus(1'b1, risc_decode_pkg::WB_ADDR_CTRL, {30'h0, i == 10, 1'b1}, 32'h0);
    for (n = 0; n < 300 && sleeping_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 300) begin
      error_cnt++;
      end_of_test();
    end
    bus(1'b1, risc_decode_pkg::WB_ADDR_ACC, 32'haa, 32'h0);
    bus(1'b0, risc_decode_pkg::WB_ADDR_ACC, {24'h0, (i == 10) ? (r[7:0] & 8'hfe) : ACC_EXP[i]}, 32'hff);
    bus(1'b0, risc_decode_pkg::WB_ADDR_STATUS, {24'h0, ST_EXP[i]}, {24'h0, ST_MSK[i]});
    bus(1'b0, risc_decode_pkg::WB_ADDR_PC, {21'h0, PC_EXP[i]}, 32'h7ff);
    bus(1'b0, risc_decode_pkg::WB_ADDR_IRQ, (i == 9) ? 32'h85 : 32'h05, 32'hff);
    bus(1'b0, risc_decode_pkg::WB_ADDR_CTRL, {30'h0, i == 10, 1'b1}, 32'h3);
    bus(1'b0, 8'h14, 32'h0, 32'hffffffff);
    check("prescaler pulses", 32'(pulses), {31'h0, i == 10});
    if (i == 10) check("port_latch_o", {8'h0, port_latch_o}, 32'h0000ff);
  endtask : run_case

  // Main sequence.
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    rst_i = 1'b1;
    port_pins_i = 24'h0;
    image = PROG[0];
    error_cnt = 0;
    n_tests = 0;
    for (int i = 0; i < 11; i++) run_case(i);
    repeat (4) @(posedge clk_i);
    check("notes left", 32'(exp_q.size()), 32'h0);
    end_of_test();
  end
endmodule : risc_instruction_decoder_tb
